// File: ssbseq_consts.svh
/*
  Timing and code constants for the buck start-up and soft-start sequencer.
  Assumes a 40 MHz system clock; all counts derive from the printed times.
*/
`ifndef SSBSEQ_CONSTS_SVH
`define SSBSEQ_CONSTS_SVH

`define SSBSEQ_CLK_MHZ          64'd40
`define SSBSEQ_NS_PER_US        64'd1000

// Fixed delay after enable
`define SSBSEQ_INIT_DELAY_NS    64'd6800000
`define SSBSEQ_INIT_DELAY_CYC \
  ((`SSBSEQ_INIT_DELAY_NS * `SSBSEQ_CLK_MHZ) / `SSBSEQ_NS_PER_US)

// Set-point sample: longest time split over the counter range
`define SSBSEQ_SAMPLE_MAX_NS    64'd3400000
`define SSBSEQ_SAMPLE_STEPS     64'd256
`define SSBSEQ_SAMPLE_STEP_CYC \
  ((`SSBSEQ_SAMPLE_MAX_NS * `SSBSEQ_CLK_MHZ) / \
   (`SSBSEQ_NS_PER_US * `SSBSEQ_SAMPLE_STEPS))
`define SSBSEQ_SAMPLE_CODE_MAX  8'hFF

// Soft-start ramp
`define SSBSEQ_SOFT_NS          64'd6800000
`define SSBSEQ_SOFT_STEPS       64'd64
`define SSBSEQ_SOFT_STEP_CYC \
  ((`SSBSEQ_SOFT_NS * `SSBSEQ_CLK_MHZ) / \
   (`SSBSEQ_NS_PER_US * `SSBSEQ_SOFT_STEPS))
`define SSBSEQ_RAMP_DONE        8'h40
`define SSBSEQ_EA_INIT_STEPS    8'h02

// Switching oscillator
`define SSBSEQ_OSC_KHZ          64'd300
`define SSBSEQ_OSC_PERIOD_CYC \
  ((`SSBSEQ_CLK_MHZ * 64'd1000) / `SSBSEQ_OSC_KHZ)

// Low-side overcurrent window and pulse stretching
`define SSBSEQ_OCP_BLANK_NS     64'd200
`define SSBSEQ_OCP_BLANK_CYC \
  ((`SSBSEQ_OCP_BLANK_NS * `SSBSEQ_CLK_MHZ + 64'd999) / `SSBSEQ_NS_PER_US)
`define SSBSEQ_LS_MIN_NS        64'd425
`define SSBSEQ_LS_MIN_CYC \
  ((`SSBSEQ_LS_MIN_NS * `SSBSEQ_CLK_MHZ + 64'd999) / `SSBSEQ_NS_PER_US)
`define SSBSEQ_NARROW_LIMIT     2'h2

`endif

// File: ssbseq_pkg.sv
/*
  Types for the buck start-up and soft-start sequencer.
  Assumes ssbseq_consts.svh carries every number.
*/
package ssbseq_pkg;

  // Gray codes along off, delay, sample, soft, run
  typedef enum logic [2:0] {
    SSBSEQ_OFF    = 3'h0,
    SSBSEQ_DELAY  = 3'h1,
    SSBSEQ_SAMPLE = 3'h3,
    SSBSEQ_SOFT   = 3'h2,
    SSBSEQ_RUN    = 3'h6,
    SSBSEQ_DUMMY1 = 3'h7,
    SSBSEQ_DUMMY2 = 3'h5
  } ssbseq_state_t;

  // Comparator and sense levels arriving from the analog side
  typedef struct packed {
    logic shutdown_released;
    logic trip_set_reached;
    logic pwm_high_req;
    logic high_gate_sense;
    logic low_gate_sense;
    logic phase_high;
    logic low_side_overcurrent;
    logic output_above_ramp;
  } ssbseq_pins_t;

endpackage

// File: ssbseq_sync.sv
/*
  Two-flop level synchroniser, width set by parameter.
  Assumes inputs are asynchronous levels; first stage feeds only the second.
*/
`timescale 1ns/10ps
`default_nettype none

module ssbseq_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: ssbseq_top.sv
/*
  Start-up, set-point sampling, soft-start, hiccup retry and gate sequencing
  for a synchronous buck controller. Assumes resetn is the supply-good
  detector and that all sense inputs are asynchronous comparator levels.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ssbseq_consts.svh"

module ssbseq_top #(
  parameter logic [19:0] INIT_DELAY_CYC = 20'(`SSBSEQ_INIT_DELAY_CYC),
  parameter logic [19:0] SOFT_STEP_CYC  = 20'(`SSBSEQ_SOFT_STEP_CYC)
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire ssbseq_pkg::ssbseq_pins_t pins,
  output var  logic                high_side_gate_drive,
  output var  logic                low_side_gate_drive,
  output var  logic                trip_set_current_en,
  output var  logic [7:0]          trip_set_dac,
  output var  logic [6:0]          soft_start_ref,
  output var  logic                err_amp_enable,
  output var  logic                osc_run,
  output var  logic                converter_ready
);

  localparam logic [19:0] SAMPLE_STEP_CYC = 20'(`SSBSEQ_SAMPLE_STEP_CYC);
  localparam logic [7:0]  OSC_PERIOD_CYC  = 8'(`SSBSEQ_OSC_PERIOD_CYC);
  localparam logic [4:0]  OCP_BLANK_CYC   = 5'(`SSBSEQ_OCP_BLANK_CYC);
  localparam logic [4:0]  LS_MIN_CYC      = 5'(`SSBSEQ_LS_MIN_CYC);

  ssbseq_pkg::ssbseq_pins_t  pins_s;
  ssbseq_pkg::ssbseq_state_t state_q;
  logic [19:0] timer_q;
  logic [19:0] timer_lim;
  logic        step_end;
  logic [7:0]  step_q;
  logic [7:0]  osc_q;
  logic        osc_tick;
  logic        gate_en_q;
  logic        trip;
  logic        ocp_armed;
  logic        switching;
  logic [4:0]  blank_q;
  logic [4:0]  lsrun_q;
  logic        wide_q;
  logic [1:0]  narrow_q;
  logic [4:0]  force_q;
  logic        force_on;
  logic        hs_d;
  logic        ls_d;

  ssbseq_sync #(
    .W ($bits(ssbseq_pkg::ssbseq_pins_t))
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .clk_en (clk_en),
    .d      (pins),
    .q      (pins_s)
  );

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      osc_q <= 8'h00;
    else if (clk_en)
    begin
      if (state_q == ssbseq_pkg::SSBSEQ_OFF || osc_tick)
        osc_q <= 8'h00;
      else
        osc_q <= osc_q + 8'h01;
    end
  end

  assign osc_tick = (osc_q == OSC_PERIOD_CYC - 8'h01);

  // sample step length; ramp step fixed
  always_comb
  begin
    unique case (state_q)
      ssbseq_pkg::SSBSEQ_DELAY:  timer_lim = INIT_DELAY_CYC;
      ssbseq_pkg::SSBSEQ_SAMPLE: timer_lim = SAMPLE_STEP_CYC;
      default:                   timer_lim = SOFT_STEP_CYC;
    endcase
  end

  assign step_end  = (timer_q == timer_lim - 20'h0_0001);
  assign switching = (state_q == ssbseq_pkg::SSBSEQ_SOFT) ||
                     (state_q == ssbseq_pkg::SSBSEQ_RUN);
  // A set point at full scale means no resistor: guard disabled
  assign ocp_armed = (trip_set_dac != `SSBSEQ_SAMPLE_CODE_MAX);

  // watch only after blanking, while low side is on
  assign trip = switching && ocp_armed && low_side_gate_drive &&
                (blank_q == OCP_BLANK_CYC) && pins_s.low_side_overcurrent;

  // sequence leaves off only with supply good and pin high
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ssbseq_pkg::SSBSEQ_OFF;
      timer_q <= 20'h0_0000;
      step_q  <= 8'h00;
    end
    else if (clk_en)
    begin
      if (!pins_s.shutdown_released)
      begin
        state_q <= ssbseq_pkg::SSBSEQ_OFF;
        timer_q <= 20'h0_0000;
        step_q  <= 8'h00;
      end
      else
      begin
        timer_q <= step_end ? 20'h0_0000 : timer_q + 20'h0_0001;
        unique case (state_q)
          ssbseq_pkg::SSBSEQ_OFF:
          begin
            state_q <= ssbseq_pkg::SSBSEQ_DELAY;
            timer_q <= 20'h0_0000;
          end
          ssbseq_pkg::SSBSEQ_DELAY:
          begin
            if (step_end)
            begin
              state_q <= ssbseq_pkg::SSBSEQ_SAMPLE;
              step_q  <= 8'h00;
            end
          end
          ssbseq_pkg::SSBSEQ_SAMPLE:
          begin
            if (step_end)
            begin
              if (pins_s.trip_set_reached ||
                  step_q == `SSBSEQ_SAMPLE_CODE_MAX)
              begin
                state_q <= ssbseq_pkg::SSBSEQ_SOFT;
                step_q  <= 8'h00;
              end
              else
                step_q <= step_q + 8'h01;
            end
          end
          ssbseq_pkg::SSBSEQ_SOFT:
          begin
            if (trip)
            begin
              state_q <= ssbseq_pkg::SSBSEQ_DUMMY1;
              timer_q <= 20'h0_0000;
              step_q  <= 8'h00;
            end
            else if (step_end)
            begin
              // done once past the last step
              if (step_q + 8'h01 == `SSBSEQ_RAMP_DONE)
                state_q <= ssbseq_pkg::SSBSEQ_RUN;
              step_q <= step_q + 8'h01;
            end
          end
          ssbseq_pkg::SSBSEQ_RUN:
          begin
            if (trip)
            begin
              state_q <= ssbseq_pkg::SSBSEQ_DUMMY1;
              timer_q <= 20'h0_0000;
              step_q  <= 8'h00;
            end
          end
          ssbseq_pkg::SSBSEQ_DUMMY1,
          ssbseq_pkg::SSBSEQ_DUMMY2:
          begin
            // each dummy is one full ramp time
            if (step_end)
            begin
              if (step_q + 8'h01 == `SSBSEQ_RAMP_DONE)
              begin
                state_q <= (state_q == ssbseq_pkg::SSBSEQ_DUMMY1) ?
                           ssbseq_pkg::SSBSEQ_DUMMY2 :
                           ssbseq_pkg::SSBSEQ_SOFT;
                step_q  <= 8'h00;
              end
              else
                step_q <= step_q + 8'h01;
            end
          end
          default:
          begin
            state_q <= ssbseq_pkg::SSBSEQ_OFF;
          end
        endcase
      end
    end
  end

  // set point held until next fresh sample
  // only the sample state writes it
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      trip_set_dac <= 8'h00;
    else if (clk_en && state_q == ssbseq_pkg::SSBSEQ_SAMPLE)
      trip_set_dac <= step_q;
  end

  // or, above target, until the ramp ends
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      gate_en_q <= 1'b0;
    else if (clk_en)
    begin
      if (!switching || trip || !pins_s.shutdown_released)
        gate_en_q <= 1'b0;
      else if (!pins_s.output_above_ramp ||
               state_q == ssbseq_pkg::SSBSEQ_RUN)
        gate_en_q <= 1'b1;
    end
  end

  // Status outputs, all registered
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      trip_set_current_en <= 1'b0;
      soft_start_ref      <= 7'h00;
      err_amp_enable      <= 1'b0;
      osc_run             <= 1'b0;
      converter_ready     <= 1'b0;
    end
    else if (clk_en)
    begin
      // trip current out while low gate is off
      trip_set_current_en <= (state_q == ssbseq_pkg::SSBSEQ_DELAY) ||
                             (state_q == ssbseq_pkg::SSBSEQ_SAMPLE);
      soft_start_ref <= (state_q == ssbseq_pkg::SSBSEQ_SOFT) ?
                        step_q[6:0] :
                        (state_q == ssbseq_pkg::SSBSEQ_RUN) ?
                        7'(`SSBSEQ_RAMP_DONE) : 7'h00;
      // amplifier on a few steps into the ramp
      err_amp_enable <= switching && !trip &&
                        ((state_q == ssbseq_pkg::SSBSEQ_RUN) ||
                         step_q >= `SSBSEQ_EA_INIT_STEPS);
      osc_run         <= (state_q != ssbseq_pkg::SSBSEQ_OFF);
      converter_ready <= (state_q == ssbseq_pkg::SSBSEQ_RUN) && !trip;
    end
  end

  // blanking counter from the low-side-on edge
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      blank_q <= 5'h00;
    else if (clk_en)
    begin
      if (!low_side_gate_drive)
        blank_q <= 5'h00;
      else if (blank_q != OCP_BLANK_CYC)
        blank_q <= blank_q + 5'h01;
    end
  end

  // count narrow periods, insert a minimum pulse
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lsrun_q  <= 5'h00;
      wide_q   <= 1'b0;
      narrow_q <= 2'h0;
      force_q  <= 5'h00;
    end
    else if (clk_en)
    begin
      lsrun_q <= low_side_gate_drive ?
                 ((lsrun_q == LS_MIN_CYC) ? lsrun_q : lsrun_q + 5'h01) :
                 5'h00;
      if (force_on && low_side_gate_drive)
        force_q <= force_q - 5'h01;
      if (!gate_en_q || !ocp_armed)
      begin
        // Stretching is moot without an armed guard
        wide_q   <= 1'b0;
        narrow_q <= 2'h0;
        force_q  <= 5'h00;
      end
      else if (osc_tick)
      begin
        wide_q <= 1'b0;
        if (wide_q || lsrun_q == LS_MIN_CYC)
          narrow_q <= 2'h0;
        else if (narrow_q == `SSBSEQ_NARROW_LIMIT - 2'h1)
        begin
          narrow_q <= 2'h0;
          force_q  <= LS_MIN_CYC;
        end
        else
          narrow_q <= narrow_q + 2'h1;
      end
      else if (lsrun_q == LS_MIN_CYC)
        wide_q <= 1'b1;
    end
  end

  assign force_on = (force_q != 5'h00);

  // each side waits for the other to be seen off
  always_comb
  begin
    hs_d = gate_en_q && !trip && pins_s.pwm_high_req && !force_on &&
           !low_side_gate_drive && !pins_s.low_gate_sense;
    ls_d = gate_en_q && !trip && (!pins_s.pwm_high_req || force_on) &&
           !high_side_gate_drive && !pins_s.high_gate_sense &&
           !pins_s.phase_high;
  end

  // gates follow enable, low in shutdown
  // a trip drops both gates next edge
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive  <= 1'b0;
    end
    else if (clk_en)
    begin
      high_side_gate_drive <= hs_d;
      low_side_gate_drive  <= ls_d;
    end
  end

endmodule

`default_nettype wire

// File: ssbseq_power_model.sv
/*
  Power stage model: gate and switch-node sense seen by the sequencer.
  Assumes gate drives are registered levels from the sequencer top.
*/
`timescale 1ns/10ps
`default_nettype none
module ssbseq_power_model (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic high_side_gate_drive,
  input  wire logic low_side_gate_drive,
  output var  logic high_gate_sense,
  output var  logic low_gate_sense,
  output var  logic phase_high
);
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      high_gate_sense <= 1'b0;
      low_gate_sense  <= 1'b0;
      phase_high      <= 1'b0;
    end
    else
    begin
      high_gate_sense <= high_side_gate_drive;
      low_gate_sense  <= low_side_gate_drive;
      // Node lags gate: off seen late
      phase_high      <= high_gate_sense;
    end
  end
endmodule
`default_nettype wire

// File: ssbseq_top_sva.sv
/*
  Checker on the sequencer top ports.
  Assumes it is bound with the counts the top was built with.
*/
`timescale 1ns/10ps
`default_nettype none
module ssbseq_chk #(
  parameter logic [19:0] INIT_DELAY_CYC = 20'h0_0028,
  parameter logic [19:0] SOFT_STEP_CYC  = 20'h0_0008
) (
  input  wire logic                     clock,
  input  wire logic                     resetn,
  input  wire logic                     clk_en,
  input  wire ssbseq_pkg::ssbseq_pins_t pins,
  input  wire logic                     high_side_gate_drive,
  input  wire logic                     low_side_gate_drive,
  input  wire logic                     trip_set_current_en,
  input  wire logic [7:0]               trip_set_dac,
  input  wire logic [6:0]               soft_start_ref,
  input  wire logic                     err_amp_enable,
  input  wire logic                     osc_run,
  input  wire logic                     converter_ready
);
  logic [6:0]  ref_q;
  logic [19:0] hold_q;
  logic [19:0] tse_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_q  <= 7'h00;
      hold_q <= 20'h0_0000;
      tse_q  <= 20'h0_0000;
    end
    else
    begin
      ref_q  <= soft_start_ref;
      hold_q <= (soft_start_ref != ref_q) ? 20'h0_0001 : hold_q + 20'h0_0001;
      tse_q  <= trip_set_current_en ? tse_q + 20'h0_0001 : 20'h0_0000;
    end
  end
  a_shut_gates_low: assert property (
    !pins.shutdown_released [*4] |=> !high_side_gate_drive
      && !low_side_gate_drive && !osc_run)
    else $error("gates or oscillator alive in shutdown");
  a_no_shoot_thru: assert property (
    !(high_side_gate_drive && low_side_gate_drive))
    else $error("both gates on");
  a_trip_set_excl: assert property (
    trip_set_current_en |-> !low_side_gate_drive && !converter_ready)
    else $error("low gate on while trip current drawn");
  a_dac_held: assert property (
    converter_ready |-> $stable(trip_set_dac))
    else $error("set point moved while running");
  a_ready_ref_full: assert property (
    converter_ready |-> soft_start_ref == 7'h40)
    else $error("ready without full ramp");
  a_ramp_single_step: assert property (
    soft_start_ref != ref_q && soft_start_ref != 7'h00
      |-> soft_start_ref == ref_q + 7'h01)
    else $error("ramp jumped");
  a_step_duration: assert property (
    soft_start_ref == ref_q + 7'h01 && ref_q != 7'h00
      |-> hold_q == SOFT_STEP_CYC)
    else $error("ramp step length wrong");
  a_ea_late: assert property (
    $rose(err_amp_enable) |-> soft_start_ref >= 7'h02)
    else $error("error amp enabled too early");
  a_delay_then_sample: assert property (
    $fell(trip_set_current_en) && osc_run
      |-> tse_q >= INIT_DELAY_CYC + 20'h0_0213)
    else $error("delay plus sample too short");
  // Eight cycles of low side on with the sense high covers blanking plus sync
  a_trip_cut: assert property (
    (converter_ready && low_side_gate_drive && trip_set_dac != 8'hff
      && pins.low_side_overcurrent) [*8]
      |-> ##[1:3] !converter_ready && !low_side_gate_drive)
    else $error("overcurrent not cut");
  c_ready: cover property ($rose(converter_ready));
  c_trip: cover property ($fell(converter_ready) && osc_run);
  c_ea: cover property ($rose(err_amp_enable));
endmodule
bind ssbseq_top ssbseq_chk #(
  .INIT_DELAY_CYC(INIT_DELAY_CYC),
  .SOFT_STEP_CYC (SOFT_STEP_CYC)
) ssbseq_chk_inst (.*);
`default_nettype wire

// File: test_buck_startup_softstart_sequencer.sv
/*
  Bench for the sequencer: start-up, pre-bias, trip retry, shutdown.
  Assumes the power stage model closes the gate sense loop.
*/
`timescale 1ns/10ps
`default_nettype none
module test_buck_startup_softstart_sequencer;
  localparam logic [19:0] ID = 20'h0_0028;
  localparam logic [19:0] SS = 20'h0_0008;
  logic                     clock, resetn, sd, tsr, pwm, ovc, oar, ovc_en;
  logic                     hs, ls, ph, hi, lo, tse, ea, osc, rdy, retry;
  logic [7:0]               dac, tgt;
  logic [6:0]               ssr, pb;
  ssbseq_pkg::ssbseq_pins_t pins;
  int                       errors, checks, n, c, bad, rs;
  assign pins = {sd, tsr, pwm, hs, ls, ph, ovc, oar};
  ssbseq_top #(.INIT_DELAY_CYC(ID), .SOFT_STEP_CYC(SS)) ssbseq_top_inst (
    .clock(clock), .resetn(resetn), .clk_en(1'b1), .pins(pins),
    .high_side_gate_drive(hi), .low_side_gate_drive(lo),
    .trip_set_current_en(tse), .trip_set_dac(dac),
    .soft_start_ref(ssr), .err_amp_enable(ea), .osc_run(osc),
    .converter_ready(rdy));
  ssbseq_power_model ssbseq_power_model_inst (
    .clock(clock), .resetn(resetn), .high_side_gate_drive(hi),
    .low_side_gate_drive(lo), .high_gate_sense(hs),
    .low_gate_sense(ls), .phase_high(ph));
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %0h got %0h", w, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wait_sig(input int s, input logic v, output int k);
    k = 0;
    do
    begin
      @(negedge clock);
      k++;
    end
    while (((s == 0 ? tse : rdy) !== v) && k < 5000);
  endtask
  function automatic int exp_init(input logic [7:0] t);
    return int'(ID) + 531 * (int'(t) + 1);
  endfunction
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Comparator and sense stimulus
  always @(negedge clock)
  begin
    tsr = (dac >= tgt);
    oar = (ssr < pb);
    ovc = ovc_en && lo;
    if ($urandom % 16 == 0)
      pwm = 1'($urandom);
    if (osc && !rdy && (hi || lo) && ssr < pb)
      bad++;
    if (retry && tse)
      rs++;
  end
  initial
  begin
    resetn = 1'b0;
    sd = 1'b0;
    tsr = 1'b0;
    pwm = 1'b0;
    ovc = 1'b0;
    oar = 1'b0;
    ovc_en = 1'b0;
    retry = 1'b0;
    tgt = 8'h00;
    pb = 7'h00;
    n = $urandom(27);
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    repeat (50) @(negedge clock);
    chk("held_off", 0, 32'({osc, tse, hi, lo}));
    for (int r = 0; r < 2; r++)
    begin
      // One-step sample first, then random
      tgt = (r == 0) ? 8'h00 : 8'($urandom_range(3, 1));
      pb = (r == 0) ? 7'h64 : 7'($urandom_range(40, 10));
      sd = 1'b1;
      wait_sig(0, 1'b1, n);
      wait_sig(0, 1'b0, c);
      chk("init_time", 1, 32'(n + c >= exp_init(tgt)
          && n + c <= exp_init(tgt) + 12));
      chk("set_point", 32'(tgt), 32'(dac));
      wait_sig(1, 1'b1, n);
      chk("ramp_time", 1, 32'(n >= 505 && n <= 518));
      chk("ramp_top", 32'h0000_0040, 32'(ssr));
      chk("ea_on", 1, 32'(ea));
      if (r == 0) chk("prebias_high", 0, 32'(bad));
      ovc_en = 1'b1;
      wait_sig(1, 1'b0, n);
      ovc_en = 1'b0;
      retry = 1'b1;
      chk("trip_gates", 0, 32'({hi, lo}));
      wait_sig(1, 1'b1, n);
      retry = 1'b0;
      chk("retry_time", 1, 32'(n >= 1530 && n <= 1545));
      chk("no_resample", 0, 32'(rs));
      chk("kept_point", 32'(tgt), 32'(dac));
      sd = 1'b0;
      repeat (5) @(negedge clock);
      chk("shutdown", 0, 32'({hi, lo, osc, rdy, ssr}));
      repeat (20) @(negedge clock);
    end
    chk("prebias_gate", 0, 32'(bad));
    wrap_up;
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
